/* File: hdl/mss_pkg.sv */
// package of constants and types for the motor starter sequencer
// How it works
// - serial, switch and keypad starts are equal
// - single direction: start closes A, stop/trip opens
// - no A feedback in 1 s: alarm, open
// - feedback after 1 s open: stuck alarm
// - reversing: start A closes and holds A
// - reversing transfer delay of 1..125 s
// - direction change: open, wait delay, close other
// - reversing: stop or trip opens closed relay
// - reversing: missing feedback opens closed relay
// - two-speed: A low; B high unless blocked
// - start block: B ignored while stopped
// - low to high: open A, close B, no delay
// - high to low: open B, wait, close A
// - two-speed: stop opens; A fault opens both
// - resistance: A, shorting delay, then B
// - resistance: stop or trip opens both
// - resistance: missing feedback opens both relays
package mss_pkg;
  // ****************************************
  // starter types
  // ****************************************
  localparam logic [1:0] TYPE_FULL_VOLTAGE_SINGLE_DIRECTION = 2'h0;
  localparam logic [1:0] TYPE_FULL_VOLTAGE_BIDIRECTIONAL = 2'h1;
  localparam logic [1:0] TYPE_TWO_SPEED = 2'h2;
  localparam logic [1:0] TYPE_SECONDARY_RESISTANCE = 2'h3;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 50000000;
  localparam int TICK_MS = 1000;
  localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;
  localparam int FEEDBACK_S = 1;
  localparam logic [6:0] FEEDBACK_TICKS = 7'h01;
  localparam logic [6:0] DELAY_MIN = 7'h01;
  localparam logic [6:0] DELAY_MAX = 7'h7d;
  localparam logic [25:0] TICK_RST = 26'h0;
  localparam logic [6:0] CNT_RST = 7'h0;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RUN_A = 5'h02,
    ST_RUN_B = 5'h04,
    ST_WAIT_A = 5'h08,
    ST_WAIT_B = 5'h10
  } mss_state_t;
endpackage

/* File: hdl/mss_sequencer.sv */
// motor starter sequencer: contactor relay sequencing and feedback supervision
`timescale 1ns/100ps
`default_nettype none
module mss_sequencer #(
  parameter int TICK_CYCLES = mss_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [1:0] starter_type,
  input wire logic [6:0] delay_sec,
  input wire logic high_speed_block,
  input wire logic start_a_serial,
  input wire logic start_a_switch,
  input wire logic start_a_keypad,
  input wire logic start_b_serial,
  input wire logic start_b_switch,
  input wire logic start_b_keypad,
  input wire logic stop_cmd,
  input wire logic trip,
  input wire logic status_a,
  input wire logic status_b,
  input wire logic alarm_clear,
  output logic relay_a,
  output logic relay_b,
  output logic open_circuit_alarm,
  output logic stuck_closed_alarm,
  output logic second_tick
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    mss_pkg::mss_state_t state;
    logic [25:0] div;
    logic tick;
    logic [6:0] seq_cnt;
    logic [6:0] sup_a;
    logic [6:0] sup_b;
    logic rel_a;
    logic rel_b;
    logic occ;
    logic weld;
  } mss_regs_t;

  mss_regs_t cur_ff;
  mss_regs_t nxt_ff;
  logic start_a;
  logic start_b;
  logic stop_any;
  logic [6:0] delay_eff;
  logic fb_miss_a;
  logic fb_miss_b;
  logic weld_a;
  logic weld_b;
  logic occ_evt;

  always_comb
  begin
    start_a = start_a_serial | start_a_switch | start_a_keypad;
    start_b = start_b_serial | start_b_switch | start_b_keypad;
    stop_any = stop_cmd | trip;
    // clamp keeps a zero or oversize setting inside the legal range
    if (delay_sec < mss_pkg::DELAY_MIN)
      delay_eff = mss_pkg::DELAY_MIN;
    else if (delay_sec > mss_pkg::DELAY_MAX)
      delay_eff = mss_pkg::DELAY_MAX;
    else
      delay_eff = delay_sec;
    fb_miss_a = cur_ff.rel_a & ~status_a & (cur_ff.sup_a >= mss_pkg::FEEDBACK_TICKS) & cur_ff.tick;
    fb_miss_b = cur_ff.rel_b & ~status_b & (cur_ff.sup_b >= mss_pkg::FEEDBACK_TICKS) & cur_ff.tick;
    weld_a = ~cur_ff.rel_a & status_a & (cur_ff.sup_a >= mss_pkg::FEEDBACK_TICKS) & cur_ff.tick;
    weld_b = ~cur_ff.rel_b & status_b & (cur_ff.sup_b >= mss_pkg::FEEDBACK_TICKS) & cur_ff.tick;
    // two-speed supervises only the low-speed relay closing
    occ_evt = fb_miss_a | (fb_miss_b & (starter_type != mss_pkg::TYPE_TWO_SPEED));
  end

  always_comb
  begin
    nxt_ff = cur_ff;
    // ****************************************
    // one second tick
    // ****************************************
    nxt_ff.tick = 1'b0;
    if (cur_ff.div >= 26'(TICK_CYCLES - 1))
    begin
      nxt_ff.div = mss_pkg::TICK_RST;
      nxt_ff.tick = 1'b1;
    end
    else
      nxt_ff.div = cur_ff.div + 26'h1;
    if (cur_ff.tick && cur_ff.seq_cnt != mss_pkg::DELAY_MAX)
      nxt_ff.seq_cnt = cur_ff.seq_cnt + 7'h1;
    if (cur_ff.tick && cur_ff.sup_a != mss_pkg::DELAY_MAX)
      nxt_ff.sup_a = cur_ff.sup_a + 7'h1;
    if (cur_ff.tick && cur_ff.sup_b != mss_pkg::DELAY_MAX)
      nxt_ff.sup_b = cur_ff.sup_b + 7'h1;
    // ****************************************
    // sequencing
    // ****************************************
    case (cur_ff.state)
      mss_pkg::ST_IDLE:
      begin
        nxt_ff.rel_a = 1'b0;
        nxt_ff.rel_b = 1'b0;
        if (!stop_any)
        begin
          if (start_a)
            nxt_ff.state = mss_pkg::ST_RUN_A;
          else if (start_b && starter_type == mss_pkg::TYPE_FULL_VOLTAGE_BIDIRECTIONAL)
            nxt_ff.state = mss_pkg::ST_RUN_B;
          else if (start_b && starter_type == mss_pkg::TYPE_TWO_SPEED && !high_speed_block)
            nxt_ff.state = mss_pkg::ST_RUN_B;
          else if (start_b && starter_type == mss_pkg::TYPE_SECONDARY_RESISTANCE)
            nxt_ff.state = mss_pkg::ST_RUN_A;
          else if (start_b && starter_type == mss_pkg::TYPE_FULL_VOLTAGE_SINGLE_DIRECTION)
            nxt_ff.state = mss_pkg::ST_RUN_A;
          nxt_ff.seq_cnt = mss_pkg::CNT_RST;
        end
      end
      mss_pkg::ST_RUN_A:
      begin
        nxt_ff.rel_a = 1'b1;
        if (starter_type == mss_pkg::TYPE_SECONDARY_RESISTANCE)
        begin
          // shorting relay waits out the delay once rel_a is set; status_a is not checked
          if (cur_ff.rel_a && cur_ff.tick && cur_ff.seq_cnt + 7'h1 >= delay_eff)
            nxt_ff.rel_b = 1'b1;
        end
        else if (start_b && starter_type == mss_pkg::TYPE_FULL_VOLTAGE_BIDIRECTIONAL)
        begin
          nxt_ff.rel_a = 1'b0;
          nxt_ff.seq_cnt = mss_pkg::CNT_RST;
          nxt_ff.state = mss_pkg::ST_WAIT_B;
        end
        else if (start_b && starter_type == mss_pkg::TYPE_TWO_SPEED)
        begin
          nxt_ff.rel_a = 1'b0;
          nxt_ff.state = mss_pkg::ST_RUN_B;
        end
      end
      mss_pkg::ST_RUN_B:
      begin
        nxt_ff.rel_b = 1'b1;
        if (start_a && starter_type != mss_pkg::TYPE_SECONDARY_RESISTANCE)
        begin
          nxt_ff.rel_b = 1'b0;
          nxt_ff.seq_cnt = mss_pkg::CNT_RST;
          nxt_ff.state = mss_pkg::ST_WAIT_A;
        end
      end
      mss_pkg::ST_WAIT_A:
      begin
        if (cur_ff.tick && cur_ff.seq_cnt + 7'h1 >= delay_eff)
          nxt_ff.state = mss_pkg::ST_RUN_A;
      end
      mss_pkg::ST_WAIT_B:
      begin
        if (cur_ff.tick && cur_ff.seq_cnt + 7'h1 >= delay_eff)
          nxt_ff.state = mss_pkg::ST_RUN_B;
      end
      default:
        nxt_ff.state = mss_pkg::ST_IDLE;
    endcase
    // stop, trip and missing feedback (except relay b in two-speed) override any sequence step
    if (stop_any || occ_evt)
    begin
      nxt_ff.rel_a = 1'b0;
      nxt_ff.rel_b = 1'b0;
      nxt_ff.state = mss_pkg::ST_IDLE;
    end
    // supervision windows restart at each relay transition
    if (nxt_ff.rel_a != cur_ff.rel_a)
      nxt_ff.sup_a = mss_pkg::CNT_RST;
    if (nxt_ff.rel_b != cur_ff.rel_b)
      nxt_ff.sup_b = mss_pkg::CNT_RST;
    // ****************************************
    // alarms: set wins over clear
    // ****************************************
    if (alarm_clear)
    begin
      nxt_ff.occ = 1'b0;
      nxt_ff.weld = 1'b0;
    end
    if (occ_evt)
      nxt_ff.occ = 1'b1;
    if (weld_a || weld_b)
      nxt_ff.weld = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_ff <= '{state: mss_pkg::ST_IDLE, div: mss_pkg::TICK_RST, tick: 1'b0,
                  seq_cnt: mss_pkg::CNT_RST, sup_a: mss_pkg::DELAY_MAX, sup_b: mss_pkg::DELAY_MAX,
                  rel_a: 1'b0, rel_b: 1'b0, occ: 1'b0, weld: 1'b0};
    end
    else
      cur_ff <= nxt_ff;
  end

  always_comb
  begin
    relay_a = cur_ff.rel_a;
    relay_b = cur_ff.rel_b;
    open_circuit_alarm = cur_ff.occ;
    stuck_closed_alarm = cur_ff.weld;
    second_tick = cur_ff.tick;
  end

  // ****************************************
  // checks
  // ****************************************
  property p_stop_opens;
    @(posedge clk_sys) disable iff (!rst_n) (stop_cmd | trip) |=> (!relay_a && !relay_b);
  endproperty
  a_stop_opens: assert property (p_stop_opens) else $error("relay closed after stop");
  property p_occ_opens;
    @(posedge clk_sys) disable iff (!rst_n) fb_miss_a |=> (open_circuit_alarm && !relay_a && !relay_b);
  endproperty
  a_occ_opens: assert property (p_occ_opens) else $error("open circuit not handled");
  property p_weld;
    @(posedge clk_sys) disable iff (!rst_n) (weld_a | weld_b) |=> stuck_closed_alarm;
  endproperty
  a_weld: assert property (p_weld) else $error("stuck alarm missing");
  property p_block;
    @(posedge clk_sys) disable iff (!rst_n)
      (cur_ff.state == mss_pkg::ST_IDLE && starter_type == mss_pkg::TYPE_TWO_SPEED && high_speed_block
       && !start_a) |=> !relay_b;
  endproperty
  a_block: assert property (p_block) else $error("blocked high start");
  property p_exclusive;
    @(posedge clk_sys) disable iff (!rst_n)
      (starter_type != mss_pkg::TYPE_SECONDARY_RESISTANCE && $stable(starter_type)) |-> !(relay_a && relay_b);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("both relays closed");
  sequence s_low_drop;
    !relay_a;
  endsequence
  sequence s_high_pick;
    relay_b;
  endsequence
  property p_low_high;
    @(posedge clk_sys) disable iff (!rst_n)
      (cur_ff.state == mss_pkg::ST_RUN_A && starter_type == mss_pkg::TYPE_TWO_SPEED && start_b && !stop_any
       && !occ_evt) |=> (s_low_drop ##1 s_high_pick);
  endproperty
  a_low_high: assert property (p_low_high) else $error("low to high failed");
  property p_tick;
    @(posedge clk_sys) disable iff (!rst_n) second_tick |=> !second_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("tick wider than one cycle");
  property p_wait_open;
    @(posedge clk_sys) disable iff (!rst_n)
      (cur_ff.state == mss_pkg::ST_WAIT_A || cur_ff.state == mss_pkg::ST_WAIT_B) |-> (!relay_a && !relay_b);
  endproperty
  a_wait_open: assert property (p_wait_open) else $error("relay closed in transfer");

  // ****************************************
  // sequence and supervision checks
  // ****************************************
  sequence s_idle_start_a;
    (cur_ff.state == mss_pkg::ST_IDLE && start_a && !stop_any) ##1 (!stop_any && !start_b);
  endsequence
  property p_start_closes;
    @(posedge clk_sys) disable iff (!rst_n)
      s_idle_start_a |=> relay_a;
  endproperty
  a_start_closes: assert property (p_start_closes) else $error("start did not close relay a");
  sequence s_idle_start_b;
    (cur_ff.state == mss_pkg::ST_IDLE && starter_type == mss_pkg::TYPE_TWO_SPEED && !high_speed_block
     && start_b && !start_a && !stop_any) ##1 (!stop_any && !start_a);
  endsequence
  property p_direct_high;
    @(posedge clk_sys) disable iff (!rst_n)
      s_idle_start_b |=> relay_b;
  endproperty
  a_direct_high: assert property (p_direct_high) else $error("direct high start failed");
  property p_reverse;
    @(posedge clk_sys) disable iff (!rst_n)
      (cur_ff.state == mss_pkg::ST_RUN_A && starter_type == mss_pkg::TYPE_FULL_VOLTAGE_BIDIRECTIONAL
       && start_b && !stop_any && !occ_evt) |=> (!relay_a && cur_ff.state == mss_pkg::ST_WAIT_B);
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse did not open forward relay");
  property p_fb_b;
    @(posedge clk_sys) disable iff (!rst_n)
      (fb_miss_b && starter_type == mss_pkg::TYPE_FULL_VOLTAGE_BIDIRECTIONAL) |=> (open_circuit_alarm && !relay_b);
  endproperty
  a_fb_b: assert property (p_fb_b) else $error("missing b feedback not handled");
  property p_res_order;
    @(posedge clk_sys) disable iff (!rst_n)
      (starter_type == mss_pkg::TYPE_SECONDARY_RESISTANCE && $rose(relay_b)) |-> $past(relay_a);
  endproperty
  a_res_order: assert property (p_res_order) else $error("shorting relay before starting relay");
  property p_res_stop;
    @(posedge clk_sys) disable iff (!rst_n)
      (starter_type == mss_pkg::TYPE_SECONDARY_RESISTANCE && stop_any) |=> (!relay_a && !relay_b);
  endproperty
  a_res_stop: assert property (p_res_stop) else $error("resistance stop left a relay closed");
  property p_occ_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      (open_circuit_alarm && !alarm_clear) |=> open_circuit_alarm;
  endproperty
  a_occ_hold: assert property (p_occ_hold) else $error("open circuit alarm dropped");
  property p_stuck_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      (stuck_closed_alarm && !alarm_clear) |=> stuck_closed_alarm;
  endproperty
  a_stuck_hold: assert property (p_stuck_hold) else $error("stuck alarm dropped");
endmodule
`default_nettype wire

/* File: test/mss_contactor_model.sv */
// contactor pair with normally open auxiliary feedback contacts
`timescale 1ns/100ps
`default_nettype none
module mss_contactor_model (
  input wire logic clk_sys,
  input wire logic relay_a,
  input wire logic relay_b,
  input wire logic no_pickup,
  input wire logic weld,
  output logic status_a,
  output logic status_b
);
  logic [1:0] dly_a_ff = 2'h0;
  logic [1:0] dly_b_ff = 2'h0;
  // coils pick up a little after the relay, so feedback is never instant
  always_ff @(posedge clk_sys)
  begin
    dly_a_ff <= {dly_a_ff[0], relay_a & ~no_pickup};
    dly_b_ff <= {dly_b_ff[0], relay_b & ~no_pickup};
  end
  // a welded tip keeps contact A closed after drop-out; status_b has no weld
  assign status_a = dly_a_ff[1] | weld;
  assign status_b = dly_b_ff[1];
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking testbench of the motor starter sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] starter_type = 2'h0;
  logic [6:0] delay_sec = 7'h02;
  logic high_speed_block = 1'b1;
  logic [8:0] cmd_v = 9'h000;
  logic no_pickup = 1'b0;
  logic weld = 1'b0;
  logic status_a, status_b, relay_a, relay_b, oc_alarm, stuck_alarm;
  logic tick_w;
  logic [7:0] n_tick = 8'h00;
  logic [7:0] t0 = 8'h00;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  always #10 clk_sys = ~clk_sys;
  // short tick so a second is 50 cycles
  mss_sequencer #(.TICK_CYCLES(50)) i_mss_sequencer (.clk_sys(clk_sys), .rst_n(rst_n),
    .starter_type(starter_type), .delay_sec(delay_sec), .high_speed_block(high_speed_block),
    .start_a_serial(cmd_v[0]), .start_a_switch(cmd_v[1]), .start_a_keypad(cmd_v[2]),
    .start_b_serial(cmd_v[3]), .start_b_switch(cmd_v[4]), .start_b_keypad(cmd_v[5]),
    .stop_cmd(cmd_v[6]), .trip(cmd_v[7]), .alarm_clear(cmd_v[8]), .status_a(status_a),
    .status_b(status_b), .relay_a(relay_a), .relay_b(relay_b), .open_circuit_alarm(oc_alarm),
    .stuck_closed_alarm(stuck_alarm), .second_tick(tick_w));
  mss_contactor_model i_mss_contactor_model (.clk_sys(clk_sys), .relay_a(relay_a), .relay_b(relay_b),
    .no_pickup(no_pickup), .weld(weld), .status_a(status_a), .status_b(status_b));
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // one-cycle pulse: bits 0-2 start a, 3-5 start b, 6 stop, 7 trip, 8 clear
  task automatic cmd(input int k);
    cmd_v[k] = 1'b1;
    step(1);
    cmd_v = 9'h000;
  endtask
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    if (tick_w)
      n_tick++;
    cycles++;
    if (cycles == 6000)
    begin
      n_fail++;
      finish_test();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    step(20);
    rst_n = 1'b1;
    step(2);
    chk({relay_a, relay_b}, 2'h0);
    t0 = n_tick;
    step(100);
    chk_cnt(n_tick - t0, 8'h02);
    for (int k = 0; k < 3; k++)
    begin
      cmd(k);
      step(3);
      chk({relay_a, relay_b}, 2'h2);
      cmd(k == 2 ? 7 : 6);
      step(2);
      chk({relay_a, relay_b}, 2'h0);
    end
    cmd(0);
    step(5);
    weld = 1'b1;
    cmd(6);
    step(110);
    chk({oc_alarm, stuck_alarm}, 2'h1);
    weld = 1'b0;
    cmd(8);
    step(3);
    chk({oc_alarm, stuck_alarm}, 2'h0);
    for (int t = 0; t < 4; t++)
    begin
      starter_type = t[1:0];
      no_pickup = 1'b1;
      cmd(t == 1 ? 3 : 0);
      step(110);
      chk({relay_a, relay_b}, 2'h0);
      chk({oc_alarm, stuck_alarm}, 2'h2);
      no_pickup = 1'b0;
      cmd(8);
      step(2);
    end
    starter_type = mss_pkg::TYPE_FULL_VOLTAGE_BIDIRECTIONAL;
    cmd(0);
    step(3);
    chk({relay_a, relay_b}, 2'h2);
    cmd(3);
    step(2);
    chk({relay_a, relay_b}, 2'h0);
    step(40);
    chk({relay_a, relay_b}, 2'h0);
    step(70);
    chk({relay_a, relay_b}, 2'h1);
    cmd(1);
    step(42);
    chk({relay_a, relay_b}, 2'h0);
    step(70);
    chk({relay_a, relay_b}, 2'h2);
    cmd(7);
    step(2);
    chk({relay_a, relay_b}, 2'h0);
    starter_type = mss_pkg::TYPE_TWO_SPEED;
    cmd(5);
    step(5);
    chk({relay_a, relay_b}, 2'h0);
    cmd(1);
    step(3);
    chk({relay_a, relay_b}, 2'h2);
    cmd(4);
    step(4);
    chk({relay_a, relay_b}, 2'h1);
    cmd(2);
    step(42);
    chk({relay_a, relay_b}, 2'h0);
    step(70);
    chk({relay_a, relay_b}, 2'h2);
    cmd(6);
    step(2);
    chk({relay_a, relay_b}, 2'h0);
    high_speed_block = 1'b0;
    cmd(3);
    step(3);
    chk({relay_a, relay_b}, 2'h1);
    cmd(7);
    step(3);
    starter_type = mss_pkg::TYPE_SECONDARY_RESISTANCE;
    cmd(2);
    step(43);
    chk({relay_a, relay_b}, 2'h2);
    step(70);
    chk({relay_a, relay_b}, 2'h3);
    cmd(6);
    step(2);
    chk({relay_a, relay_b}, 2'h0);
    chk({oc_alarm, stuck_alarm}, 2'h0);
    delay_sec = 7'h00;
    cmd(2);
    step(60);
    chk({relay_a, relay_b}, 2'h3);
    cmd(6);
    step(2);
    chk({relay_a, relay_b}, 2'h0);
    finish_test();
  end
endmodule
`default_nettype wire
